// ===== hdl/pgen_frame_timing.sv
// Function
// - Line size is a 16-bit active byte count, low byte resets 0x80, 1920 total.
// - Bar width in bytes sizes every bar but the last; resets 0x00f0.
// - Last bar takes whatever bytes of the line remain.
// - Active lines per frame are 16 bits, high byte resets 0x01, 480 total.
// - Total lines per frame counts blanking plus active lines; low byte resets 0x0d.
// - Line period is 16 bits in 10 ns steps; resets to 31.75 us.
// - Back porch blank lines follow FrameStart before the first active line.
// - Front porch blank lines follow the last active line before FrameEnd.
// - Line size high byte lives at page 0 offset 0x04, resetting to 0x07.
// - Patterns start only while enabled, and a running frame completes after disable; type bit picks colour bars or fixed colour.
`timescale 1ns/1ps
module pgen_frame_timing (
   input  wire logic                  clk_sys,
   input  wire logic                  srst,
   input  wire pgen_pkg::reg_req_type reg_req,
   output pgen_pkg::reg_rsp_type      reg_rsp,
   output pgen_pkg::video_out_type    video
);
   import pgen_pkg::*;

   typedef struct packed {
      logic [7:0]    ind_ctl;
      logic [7:0]    ind_offset;
      logic          rd_pend;
      logic [7:0]    rd_sel;
      logic          rd_page_ok;
      reg_rsp_type   rsp;
      gen_state_type fsm;
      logic [15:0]   line_idx;
      logic [15:0]   elapsed;
      logic [15:0]   byte_cnt;
      logic [15:0]   bar_byte;
      logic [2:0]    bar_idx;
      logic [3:0]    blk_idx;
      video_out_type video;
   } top_state_type;

   localparam top_state_type RST_STATE = '{
      ind_ctl:    RST_IND_CTL,
      ind_offset: RST_IND_ADDR,
      rd_pend:    1'b0,
      rd_sel:     8'h00,
      rd_page_ok: 1'b0,
      rsp:        '0,
      fsm:        GEN_IDLE,
      line_idx:   16'h0000,
      elapsed:    16'h0000,
      byte_cnt:   16'h0000,
      bar_byte:   16'h0000,
      bar_idx:    3'h0,
      blk_idx:    4'h0,
      video:      '0
   };

   top_state_type  state_reg;
   top_state_type  state_next;
   page_image_type page;
   logic [7:0]     page_rdata;
   logic           page_sel;
   logic           data_access;
   logic           page_wr;
   logic           page_rd;

   assign page_sel    = (state_reg.ind_ctl[CTL_SELECT_LSB +: 4] == PAGE_PGEN);
   // Auto-increment counts every data access, selected page or not
   assign data_access = (reg_req.wr || reg_req.rd) && (reg_req.addr == MAIN_IND_DATA);
   assign page_wr     = reg_req.wr && (reg_req.addr == MAIN_IND_DATA) && page_sel;
   assign page_rd     = reg_req.rd && (reg_req.addr == MAIN_IND_DATA) && page_sel;

   // Generator reads the image directly; the window adds a write port and a registered read port
   pgen_page_regs u_page (
      .clk_sys (clk_sys),
      .srst    (srst),
      .wr_en   (page_wr),
      .rd_en   (page_rd),
      .addr    (state_reg.ind_offset),
      .wdata   (reg_req.wdata),
      .rdata   (page_rdata),
      .page    (page)
   );

   // Settings, each pair joined high byte over low byte
   logic [15:0] line_bytes;
   logic [15:0] bar_width;
   logic [15:0] active_lines;
   logic [15:0] total_lines;
   logic [15:0] line_period;
   logic [15:0] back_porch;
   logic [15:0] front_porch;
   logic        enable;
   logic        fixed_colour;
   logic [2:0]  last_bar;
   logic [3:0]  block_size;

   always_comb begin
      line_bytes   = {page[OFF_LINE_BYTES_HIGH[4:0]], page[OFF_LINE_BYTES_LOW[4:0]]};
      bar_width    = {page[OFF_BAR_WIDTH_HIGH[4:0]], page[OFF_BAR_WIDTH_LOW[4:0]]};
      active_lines = {page[OFF_ACTIVE_LINES_HI[4:0]], page[OFF_ACTIVE_LINES_LO[4:0]]};
      total_lines  = {page[OFF_TOTAL_LINES_HI[4:0]], page[OFF_TOTAL_LINES_LO[4:0]]};
      line_period  = {page[OFF_LINE_PERIOD_HI[4:0]], page[OFF_LINE_PERIOD_LO[4:0]]};
      // Porch counts are 8 bits, zero-extended for the layout sums
      back_porch   = {8'h00, page[OFF_BACK_PORCH[4:0]]};
      front_porch  = {8'h00, page[OFF_FRONT_PORCH[4:0]]};
      enable       = page[OFF_GEN_CTL[4:0]][ENABLE_BIT];
      fixed_colour = page[OFF_GEN_CFG[4:0]][FIXED_BIT];
      block_size   = page[OFF_GEN_CFG[4:0]][BLOCK_SIZE_LSB +: 4];
      // Bar count is a power of two; last_bar is the final bar's index
      case (page[OFF_GEN_CFG[4:0]][NUM_BARS_LSB +: 2])
         2'b00:   last_bar = 3'd0;
         2'b01:   last_bar = 3'd1;
         2'b10:   last_bar = 3'd3;
         default: last_bar = 3'd7;
      endcase
   end

   // Frame layout as line index boundaries; wide enough not to wrap
   logic [17:0] active_first;
   logic [17:0] active_end;
   logic [17:0] frame_end_idx;

   assign active_first  = {2'b00, back_porch};
   assign active_end    = active_first + {2'b00, active_lines};
   assign frame_end_idx = active_end + {2'b00, front_porch};

   logic [16:0] idx_inc;
   logic [16:0] elapsed_sum;
   logic [15:0] elapsed_n;
   logic        period_done;
   logic        line_is_active;
   logic        emit;
   logic [15:0] byte_cnt_n;
   logic [4:0]  colour_addr;

   always_comb begin
      idx_inc        = {1'b0, state_reg.line_idx} + 17'd1;
      elapsed_sum    = {1'b0, state_reg.elapsed} + {1'b0, UNITS_PER_CLK};
      // Saturate so a long period never wraps back to a short one
      if (elapsed_sum[16]) begin
         elapsed_n   = 16'hffff;
      end else begin
         elapsed_n   = elapsed_sum[15:0];
      end
      period_done    = (elapsed_n >= line_period);
      line_is_active = ({2'b00, state_reg.line_idx} >= active_first) &&
                       ({2'b00, state_reg.line_idx} < active_end);
      emit           = line_is_active && (state_reg.byte_cnt < line_bytes);
      byte_cnt_n     = state_reg.byte_cnt + 16'(emit);
      // Fixed mode walks the colour bytes by block, bar mode by bar
      colour_addr    = fixed_colour ? OFF_COLOUR_BASE[4:0] + {1'b0, state_reg.blk_idx}
                                    : OFF_COLOUR_BASE[4:0] + {2'b00, state_reg.bar_idx};
   end

   always_comb begin
      state_next = state_reg;
      // Pulses default low and are raised below for one cycle only
      state_next.rsp.rvalid = 1'b0;
      state_next.video      = '0;

      // Main-space window
      if (reg_req.wr) begin
         case (reg_req.addr)
            MAIN_IND_CTL:  state_next.ind_ctl    = reg_req.wdata;
            MAIN_IND_ADDR: state_next.ind_offset = reg_req.wdata;
            default:       state_next.ind_ctl    = state_next.ind_ctl;
         endcase
      end
      if (data_access && state_reg.ind_ctl[CTL_AUTO_INC]) begin
         state_next.ind_offset = state_reg.ind_offset + 8'h01;
      end
      state_next.rd_pend = reg_req.rd;
      if (reg_req.rd) begin
         state_next.rd_sel     = reg_req.addr;
         // Another block selected: the page read port holds stale data
         state_next.rd_page_ok = page_sel;
      end
      if (state_reg.rd_pend) begin
         state_next.rsp.rvalid = 1'b1;
         case (state_reg.rd_sel)
            MAIN_IND_CTL:  state_next.rsp.rdata = state_reg.ind_ctl;
            MAIN_IND_ADDR: state_next.rsp.rdata = state_reg.ind_offset;
            MAIN_IND_DATA: state_next.rsp.rdata = state_reg.rd_page_ok ? page_rdata : 8'h00;
            default:       state_next.rsp.rdata = 8'h00;
         endcase
      end

      // Frame generator
      case (state_reg.fsm)
         // Enable is looked at only between frames
         GEN_IDLE: begin
            if (enable) begin
               state_next.fsm = GEN_FS;
            end
         end
         GEN_FS: begin
            state_next.video.frame_start = 1'b1;
            state_next.line_idx = 16'h0000;
            state_next.elapsed  = 16'h0000;
            state_next.byte_cnt = 16'h0000;
            state_next.bar_byte = 16'h0000;
            state_next.bar_idx  = 3'h0;
            state_next.blk_idx  = 4'h0;
            // An empty layout still brackets the frame with FrameEnd
            if (frame_end_idx == 18'h0) begin
               state_next.fsm = GEN_FE;
            end else begin
               state_next.fsm = GEN_LINE;
            end
         end
         GEN_LINE: begin
            // Every porch or active line is marked in its first cycle
            if (state_reg.elapsed == 16'h0000) begin
               state_next.video.line_start  = 1'b1;
               state_next.video.line_active = line_is_active;
            end
            state_next.elapsed = elapsed_n;
            if (emit) begin
               state_next.video.byte_valid = 1'b1;
               state_next.video.byte_data  = page[colour_addr];
               state_next.byte_cnt         = byte_cnt_n;
               if (fixed_colour) begin
                  // A block size of zero behaves as one byte per block
                  if ({1'b0, state_reg.blk_idx} + 5'd1 >= {1'b0, block_size}) begin
                     state_next.blk_idx = 4'h0;
                  end else begin
                     state_next.blk_idx = state_reg.blk_idx + 4'h1;
                  end
               end else if (state_reg.bar_idx != last_bar &&
                            state_reg.bar_byte + 16'h0001 >= bar_width) begin
                  state_next.bar_idx  = state_reg.bar_idx + 3'h1;
                  state_next.bar_byte = 16'h0000;
               end else begin
                  // Final bar keeps counting until the line runs out
                  state_next.bar_byte = state_reg.bar_byte + 16'h0001;
               end
            end
            // A line lasts the period, or longer if its bytes are not yet out
            if (period_done && (!line_is_active || byte_cnt_n >= line_bytes)) begin
               state_next.line_idx = idx_inc[15:0];
               state_next.elapsed  = 16'h0000;
               state_next.byte_cnt = 16'h0000;
               state_next.bar_byte = 16'h0000;
               state_next.bar_idx  = 3'h0;
               state_next.blk_idx  = 4'h0;
               if ({1'b0, idx_inc} >= frame_end_idx) begin
                  state_next.fsm = GEN_FE;
               end
            end
         end
         GEN_FE: begin
            state_next.video.frame_end = 1'b1;
            state_next.elapsed = 16'h0000;
            // No padding when porches and active lines already fill the frame
            if (state_reg.line_idx >= total_lines) begin
               if (enable) begin
                  state_next.fsm = GEN_FS;
               end else begin
                  state_next.fsm = GEN_IDLE;
               end
            end else begin
               state_next.fsm = GEN_PAD;
            end
         end
         // Padding lines carry no markers, only time
         GEN_PAD: begin
            state_next.elapsed = elapsed_n;
            if (period_done) begin
               state_next.line_idx = idx_inc[15:0];
               state_next.elapsed  = 16'h0000;
               // Disable is honoured here so a running frame always completes
               if (idx_inc >= {1'b0, total_lines}) begin
                  if (enable) begin
                     state_next.fsm = GEN_FS;
                  end else begin
                     state_next.fsm = GEN_IDLE;
                  end
               end
            end
         end
         default: begin
            state_next.fsm = GEN_IDLE;
         end
      endcase
   end

   // Synchronous reset returns every field, outputs included, to idle
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= RST_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign reg_rsp = state_reg.rsp;
   assign video   = state_reg.video;

endmodule

// ===== hdl/pgen_pkg.sv
package pgen_pkg;

   // Main register space: the indirect access window
   localparam logic [7:0] MAIN_IND_CTL   = 8'hb0;
   localparam logic [7:0] MAIN_IND_ADDR  = 8'hb1;
   localparam logic [7:0] MAIN_IND_DATA  = 8'hb2;
   localparam int         CTL_SELECT_LSB = 2;
   localparam int         CTL_AUTO_INC   = 1;
   localparam logic [3:0] PAGE_PGEN      = 4'h0;
   localparam logic [7:0] RST_IND_CTL    = 8'h00;
   localparam logic [7:0] RST_IND_ADDR   = 8'h00;

   // Indirect page 0 offsets
   localparam logic [7:0] OFF_GEN_CTL          = 8'h01;
   localparam logic [7:0] OFF_GEN_CFG          = 8'h02;
   localparam logic [7:0] OFF_CSI_ID           = 8'h03;
   localparam logic [7:0] OFF_LINE_BYTES_HIGH  = 8'h04;
   localparam logic [7:0] OFF_LINE_BYTES_LOW   = 8'h05;
   localparam logic [7:0] OFF_BAR_WIDTH_HIGH   = 8'h06;
   localparam logic [7:0] OFF_BAR_WIDTH_LOW    = 8'h07;
   localparam logic [7:0] OFF_ACTIVE_LINES_HI  = 8'h08;
   localparam logic [7:0] OFF_ACTIVE_LINES_LO  = 8'h09;
   localparam logic [7:0] OFF_TOTAL_LINES_HI   = 8'h0a;
   localparam logic [7:0] OFF_TOTAL_LINES_LO   = 8'h0b;
   localparam logic [7:0] OFF_LINE_PERIOD_HI   = 8'h0c;
   localparam logic [7:0] OFF_LINE_PERIOD_LO   = 8'h0d;
   localparam logic [7:0] OFF_BACK_PORCH       = 8'h0e;
   localparam logic [7:0] OFF_FRONT_PORCH      = 8'h0f;
   localparam logic [7:0] OFF_COLOUR_BASE      = 8'h10;

   // Reset values
   localparam logic [7:0] RST_GEN_CTL          = 8'h00;
   localparam logic [7:0] RST_GEN_CFG          = 8'h33;
   localparam logic [7:0] RST_CSI_ID           = 8'h24;
   localparam logic [7:0] RST_LINE_BYTES_HIGH  = 8'h07;
   localparam logic [7:0] RST_LINE_BYTES_LOW   = 8'h80;
   localparam logic [7:0] RST_BAR_WIDTH_HIGH   = 8'h00;
   localparam logic [7:0] RST_BAR_WIDTH_LOW    = 8'hf0;
   localparam logic [7:0] RST_ACTIVE_LINES_HI  = 8'h01;
   localparam logic [7:0] RST_ACTIVE_LINES_LO  = 8'he0;
   localparam logic [7:0] RST_TOTAL_LINES_HI   = 8'h02;
   localparam logic [7:0] RST_TOTAL_LINES_LO   = 8'h0d;
   localparam logic [7:0] RST_LINE_PERIOD_HI   = 8'h0c;
   localparam logic [7:0] RST_LINE_PERIOD_LO   = 8'h67;
   localparam logic [7:0] RST_BACK_PORCH       = 8'h0b;
   localparam logic [7:0] RST_FRONT_PORCH      = 8'h0a;
   localparam logic [7:0][7:0] RST_COLOURS     = {8'h80, 8'h0f, 8'hcc, 8'h55,
                                                  8'h7f, 8'hf0, 8'h33, 8'haa};

   // Field positions
   localparam int ENABLE_BIT     = 0;
   localparam int FIXED_BIT      = 7;
   localparam int NUM_BARS_LSB   = 4;
   localparam int BLOCK_SIZE_LSB = 0;

   localparam int PAGE_DEPTH = 32;
   localparam int PAGE_AW    = 5;

   // Line period is counted in 10 ns units, the clock is 50 ns
   localparam int          CLK_PERIOD_NS  = 50;
   localparam int          LINE_UNIT_NS   = 10;
   localparam logic [15:0] UNITS_PER_CLK  = 16'(CLK_PERIOD_NS / LINE_UNIT_NS);

   typedef logic [PAGE_DEPTH-1:0][7:0] page_image_type;

   function automatic page_image_type page0_reset_image();
      page_image_type img;
      img = '0;
      img[OFF_GEN_CTL[4:0]]         = RST_GEN_CTL;
      img[OFF_GEN_CFG[4:0]]         = RST_GEN_CFG;
      img[OFF_CSI_ID[4:0]]          = RST_CSI_ID;
      img[OFF_LINE_BYTES_HIGH[4:0]] = RST_LINE_BYTES_HIGH;
      img[OFF_LINE_BYTES_LOW[4:0]]  = RST_LINE_BYTES_LOW;
      img[OFF_BAR_WIDTH_HIGH[4:0]]  = RST_BAR_WIDTH_HIGH;
      img[OFF_BAR_WIDTH_LOW[4:0]]   = RST_BAR_WIDTH_LOW;
      img[OFF_ACTIVE_LINES_HI[4:0]] = RST_ACTIVE_LINES_HI;
      img[OFF_ACTIVE_LINES_LO[4:0]] = RST_ACTIVE_LINES_LO;
      img[OFF_TOTAL_LINES_HI[4:0]]  = RST_TOTAL_LINES_HI;
      img[OFF_TOTAL_LINES_LO[4:0]]  = RST_TOTAL_LINES_LO;
      img[OFF_LINE_PERIOD_HI[4:0]]  = RST_LINE_PERIOD_HI;
      img[OFF_LINE_PERIOD_LO[4:0]]  = RST_LINE_PERIOD_LO;
      img[OFF_BACK_PORCH[4:0]]      = RST_BACK_PORCH;
      img[OFF_FRONT_PORCH[4:0]]     = RST_FRONT_PORCH;
      for (int i = 0; i < 8; i++) begin
         img[OFF_COLOUR_BASE[4:0] + 5'(i)] = RST_COLOURS[i];
      end
      return img;
   endfunction

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_type;

   typedef struct packed {
      logic       rvalid;
      logic [7:0] rdata;
   } reg_rsp_type;

   typedef struct packed {
      logic       frame_start;
      logic       frame_end;
      logic       line_start;
      logic       line_active;
      logic       byte_valid;
      logic [7:0] byte_data;
   } video_out_type;

   typedef enum logic [4:0] {
      GEN_IDLE  = 5'b00001,
      GEN_FS    = 5'b00010,
      GEN_LINE  = 5'b00100,
      GEN_FE    = 5'b01000,
      GEN_PAD   = 5'b10000
   } gen_state_type;

endpackage

// ===== hdl/pgen_page_regs.sv
`timescale 1ns/1ps
module pgen_page_regs (
   input  wire logic                    clk_sys,
   input  wire logic                    srst,
   input  wire logic                    wr_en,
   input  wire logic                    rd_en,
   input  wire logic [7:0]              addr,
   input  wire logic [7:0]              wdata,
   output logic [7:0]                   rdata,
   output pgen_pkg::page_image_type     page
);
   import pgen_pkg::*;

   typedef struct packed {
      page_image_type mem;
      logic [7:0]     rdata;
   } page_state_type;

   localparam page_state_type RST_STATE = '{mem: page0_reset_image(), rdata: 8'h00};

   page_state_type state_reg;
   page_state_type state_next;
   logic           hit;

   // Offsets above the page image read as zero and ignore writes
   assign hit = (addr < 8'(PAGE_DEPTH));

   always_comb begin
      state_next = state_reg;
      if (wr_en && hit) begin
         state_next.mem[addr[PAGE_AW-1:0]] = wdata;
      end
      if (rd_en) begin
         state_next.rdata = hit ? state_reg.mem[addr[PAGE_AW-1:0]] : 8'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= RST_STATE;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign page  = state_reg.mem;

endmodule

// ===== sim/pgen_frame_timing_properties.sv
`timescale 1ns/1ps
module pgen_frame_timing_properties (
   input wire logic                    clk_sys,
   input wire logic                    srst,
   input wire pgen_pkg::reg_req_type   reg_req,
   input wire pgen_pkg::reg_rsp_type   reg_rsp,
   input wire pgen_pkg::video_out_type video
);
   import pgen_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   logic known_addr;
   assign known_addr = reg_req.addr inside {MAIN_IND_CTL, MAIN_IND_ADDR, MAIN_IND_DATA};

   sequence read_taken;
      reg_req.rd;
   endsequence
   sequence answer_two;
      ##2 reg_rsp.rvalid;
   endsequence

   a_read_answer:
      assert property (read_taken |-> answer_two) else $error("read not answered in two edges");
   a_answer_cause:
      assert property (reg_rsp.rvalid |-> $past(reg_req.rd, 2)) else $error("answer without read");
   a_unmapped_zero:
      assert property ((reg_req.rd && !known_addr) |-> ##2 reg_rsp.rdata == 8'h00)
      else $error("unmapped read not zero");
   a_line_after_fs:
      assert property (video.frame_start |=> (video.line_start || video.frame_end))
      else $error("frame start not followed by line or end");
   a_active_bytes:
      assert property (video.line_start && video.line_active |-> video.byte_valid)
      else $error("active line without first byte");
   a_blank_line:
      assert property (video.line_start && !video.line_active |-> !video.byte_valid)
      else $error("blank line carries bytes");
   a_idle_data:
      assert property (!video.byte_valid |-> video.byte_data == 8'h00)
      else $error("data without valid");
   a_bytes_run:
      assert property (video.byte_valid && !video.line_start |-> $past(video.byte_valid))
      else $error("gap inside active line");
   a_reset_quiet:
      assert property (disable iff (1'b0) srst |=> (video == '0 && !reg_rsp.rvalid))
      else $error("outputs active after reset");
endmodule

// ===== sim/csi_rx_model.sv
`timescale 1ns/1ps
module csi_rx_model (
   input  wire logic                    clk_sys,
   input  wire logic                    srst,
   input  wire pgen_pkg::video_out_type video,
   output logic [15:0]                  frames,
   output logic [15:0]                  lines_seen,
   output logic [15:0]                  act_seen,
   output logic [15:0]                  bp_seen,
   output logic [15:0]                  fp_seen,
   output logic [15:0]                  line_gap,
   output logic [15:0]                  end_gap,
   output logic [15:0]                  bytes_seen,
   output logic [7:0]                   line_buf [16]
);
   import pgen_pkg::*;
   logic [15:0] cyc, ls_at, fe_at, lines, act, bp, fp, idx;
   // Byte index restarts on the line_start cycle, which carries byte 0
   assign idx = video.line_start ? 16'h0000 : bytes_seen;

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         {cyc, ls_at, fe_at, lines, act, bp, fp, frames, bytes_seen} <= '0;
      end else begin
         cyc <= cyc + 16'h0001;
         if (video.frame_end) fe_at <= cyc;
         if (video.frame_start) begin
            frames <= frames + 16'h0001;
            {lines_seen, act_seen, bp_seen, fp_seen} <= {lines, act, bp, fp};
            {lines, act, bp, fp} <= '0;
            end_gap <= cyc - fe_at;
         end
         if (video.line_start) begin
            lines <= lines + 16'h0001;
            line_gap <= cyc - ls_at;
            ls_at <= cyc;
            if (video.line_active) act <= act + 16'h0001;
            else if (act == 16'h0000) bp <= bp + 16'h0001;
            else fp <= fp + 16'h0001;
         end
         if (video.byte_valid) begin
            line_buf[idx[3:0]] <= video.byte_data;
            bytes_seen <= idx + 16'h0001;
         end
      end
   end
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import pgen_pkg::*;
   logic          clk_sys = 1'b0;
   logic          srst = 1'b1;
   reg_req_type   reg_req = '0;
   reg_rsp_type   reg_rsp;
   video_out_type video;
   logic [15:0]   frames, lines_seen, act_seen, bp_seen, fp_seen, line_gap, end_gap, bytes_seen;
   logic [15:0]   gap0;
   logic [7:0]    line_buf [16];
   logic [7:0]    rd;
   int            fails = 0;
   int            samples_checked = 0;
   int            cycles = 0;
   // Line 10 bytes, bars 3 wide, 3 active of 6 lines, period 50 units
   logic [7:0]    cfg_vals [12] = '{8'h00, 8'h0a, 8'h00, 8'h03, 8'h00, 8'h03,
                                    8'h00, 8'h06, 8'h00, 8'h32, 8'h02, 8'h01};

   always #25 clk_sys = ~clk_sys;

   pgen_frame_timing pgen_frame_timing_i (.clk_sys(clk_sys), .srst(srst), .reg_req(reg_req),
                                          .reg_rsp(reg_rsp), .video(video));
   csi_rx_model csi_rx_model_i (.clk_sys(clk_sys), .srst(srst), .video(video), .frames(frames),
      .lines_seen(lines_seen), .act_seen(act_seen), .bp_seen(bp_seen), .fp_seen(fp_seen),
      .line_gap(line_gap), .end_gap(end_gap), .bytes_seen(bytes_seen), .line_buf(line_buf));

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         $display("unexpected at %0t: run hung", $time);
         stop_test();
      end
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_req.wr = 1'b1;
      reg_req.addr = a;
      reg_req.wdata = d;
      @(negedge clk_sys);
      reg_req.wr = 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_req.rd = 1'b1;
      reg_req.addr = a;
      @(negedge clk_sys);
      reg_req.rd = 1'b0;
      for (int i = 0; i < 4 && reg_rsp.rvalid !== 1'b1; i++) @(negedge clk_sys);
      d = (reg_rsp.rvalid === 1'b1) ? reg_rsp.rdata : 8'hxx;
   endtask

   // Page 0 with auto increment
   task automatic seek(input logic [7:0] off);
      wr_reg(MAIN_IND_CTL, 8'h02);
      wr_reg(MAIN_IND_ADDR, off);
   endtask

   task automatic wait_frames(input int n);
      for (int i = 0; i < 3000 && n > 0; i++) begin
         @(negedge clk_sys);
         if (video.frame_start === 1'b1) n--;
      end
      @(negedge clk_sys);
      check(16'(n), 16'h0000);
   endtask

   task automatic t_reset_values;
      logic [7:0] exp [12];
      exp = '{RST_LINE_BYTES_HIGH, RST_LINE_BYTES_LOW, RST_BAR_WIDTH_HIGH, RST_BAR_WIDTH_LOW,
              RST_ACTIVE_LINES_HI, RST_ACTIVE_LINES_LO, RST_TOTAL_LINES_HI, RST_TOTAL_LINES_LO,
              RST_LINE_PERIOD_HI, RST_LINE_PERIOD_LO, RST_BACK_PORCH, RST_FRONT_PORCH};
      seek(OFF_LINE_BYTES_HIGH);
      for (int i = 0; i < 12; i++) begin
         rd_reg(MAIN_IND_DATA, rd);
         check({8'h00, rd}, {8'h00, exp[i]});
      end
      rd_reg(8'hb3, rd);
      check({8'h00, rd}, 16'h0000);
      wr_reg(MAIN_IND_CTL, 8'h04);
      rd_reg(MAIN_IND_DATA, rd);
      check({8'h00, rd}, 16'h0000);
   endtask

   task automatic t_config;
      seek(OFF_LINE_BYTES_HIGH);
      for (int i = 0; i < 12; i++) wr_reg(MAIN_IND_DATA, cfg_vals[i]);
      seek(OFF_GEN_CFG);
      wr_reg(MAIN_IND_DATA, 8'h23);
      seek(OFF_LINE_BYTES_HIGH);
      for (int i = 0; i < 12; i++) begin
         rd_reg(MAIN_IND_DATA, rd);
         check({8'h00, rd}, {8'h00, cfg_vals[i]});
      end
      seek(OFF_GEN_CTL);
      wr_reg(MAIN_IND_DATA, 8'h01);
      wait_frames(3);
   endtask

   task automatic t_bars;
      check(lines_seen, 16'd6);
      check(bp_seen, 16'd2);
      check(act_seen, 16'd3);
      check(fp_seen, 16'd1);
      check(line_gap, 16'd10);
      check(bytes_seen, 16'd10);
      for (int i = 0; i < 9; i++) begin
         check({8'h00, line_buf[i]}, {8'h00, RST_COLOURS[i/3]});
      end
      check({8'h00, line_buf[9]}, {8'h00, RST_COLOURS[3]});
      gap0 = end_gap;
   endtask

   task automatic t_padding;
      seek(OFF_TOTAL_LINES_LO);
      wr_reg(MAIN_IND_DATA, 8'h09);
      wait_frames(2);
      check(end_gap, gap0 + 16'd30);
      check(lines_seen, 16'd6);
   endtask

   task automatic t_fixed;
      seek(OFF_GEN_CFG);
      wr_reg(MAIN_IND_DATA, 8'h83);
      wait_frames(2);
      for (int i = 0; i < 10; i++) begin
         check({8'h00, line_buf[i]}, {8'h00, RST_COLOURS[i%3]});
      end
   endtask

   // Two bars: bar 0 is 3 bytes, the last bar takes the other 7
   task automatic t_two_bars;
      seek(OFF_GEN_CFG);
      wr_reg(MAIN_IND_DATA, 8'h13);
      wait_frames(2);
      for (int i = 0; i < 10; i++) begin
         check({8'h00, line_buf[i]}, {8'h00, RST_COLOURS[(i < 3) ? 0 : 1]});
      end
   endtask

   task automatic t_disable;
      logic [15:0] f;
      seek(OFF_GEN_CTL);
      wr_reg(MAIN_IND_DATA, 8'h00);
      repeat (200) @(negedge clk_sys);
      f = frames;
      repeat (300) @(negedge clk_sys);
      check(frames, f);
   endtask

   initial begin
      repeat (4) @(negedge clk_sys);
      srst = 1'b0;
      t_reset_values();
      t_config();
      t_bars();
      t_padding();
      t_fixed();
      t_two_bars();
      t_disable();
      stop_test();
   end
endmodule

bind pgen_frame_timing pgen_frame_timing_properties pgen_frame_timing_properties_i (
   .clk_sys(clk_sys), .srst(srst), .reg_req(reg_req), .reg_rsp(reg_rsp), .video(video));
